// ==== core/asr_consts.svh ====
// constants of the serial register-access front end
`ifndef ASR_CONSTS_SVH
`define ASR_CONSTS_SVH

// register target codes on the serial side
`define ASR_SEL_COMM 3'h0
`define ASR_SEL_SETUP 3'h1
`define ASR_SEL_CLOCK 3'h2
`define ASR_SEL_DATA 3'h3
`define ASR_SEL_TEST 3'h4
`define ASR_SEL_NOP 3'h5
`define ASR_SEL_OFFS 3'h6
`define ASR_SEL_GAIN 3'h7

// serial register widths in bits
`define ASR_W8 5'h08
`define ASR_W16 5'h10
`define ASR_W24 5'h18

// command word field positions
`define ASR_CMD_SEL_HI 6
`define ASR_CMD_SEL_LO 4
`define ASR_CMD_RD 3
`define ASR_CMD_HOLD 2
`define ASR_CMD_CH_HI 1
`define ASR_CMD_CH_LO 0
`define ASR_CMD_BITS 5'h07

// setup register field positions
`define ASR_SU_MODE_HI 7
`define ASR_SU_MODE_LO 6
`define ASR_SU_GAIN_HI 5
`define ASR_SU_GAIN_LO 3
`define ASR_SU_UNI 2
`define ASR_SU_BUF 1
`define ASR_SU_SYNC 0

// clock register field positions
`define ASR_CK_DIS 4
`define ASR_CK_HALVE 3
`define ASR_CK_MSEL 2
`define ASR_CK_FS_HI 1
`define ASR_CK_FS_LO 0

// reset values
`define ASR_RST_COMM 7'h00
`define ASR_RST_SETUP 8'h00
`define ASR_RST_CLOCK 8'h00
`define ASR_RST_TEST 8'h00
`define ASR_RST_DATA 16'h0000
`define ASR_RST_OFFS 24'h000000
`define ASR_RST_GAIN 24'h000000

// resync: ones in a row on the data pin before the one that resets the interface
`define ASR_RESYNC_ONES 5'h1F

// output update rates in Hz, by master clock
`define ASR_RATE_FAST_0 16'h0032
`define ASR_RATE_FAST_1 16'h003C
`define ASR_RATE_FAST_2 16'h00FA
`define ASR_RATE_FAST_3 16'h01F4
`define ASR_RATE_SLOW_0 16'h0014
`define ASR_RATE_SLOW_1 16'h0019
`define ASR_RATE_SLOW_2 16'h0064
`define ASR_RATE_SLOW_3 16'h00C8

// axi4-lite byte addresses
`define ASR_A_STATUS 8'h00
`define ASR_A_MASK 8'h04
`define ASR_A_RESULT 8'h08
`define ASR_A_SERIAL 8'h0C

// status bits
`define ASR_EV_CMD 0
`define ASR_EV_WR 1
`define ASR_EV_RD 2
`define ASR_EV_SYNC 3

`define ASR_RESP_OKAY 2'h0
`define ASR_RESP_SLVERR 2'h2

`endif

// ==== core/asr_pkg.sv ====
// types of the serial register-access front end
package asr_pkg;

    typedef enum logic [1:0] {
        ASR_PH_CMD,
        ASR_PH_WR,
        ASR_PH_RD
    } asr_phase_t;

    // configuration driven out to the converter
    typedef struct packed {
        logic low_power_hold;
        logic [1:0] input_channel_select;
        logic [1:0] cal_mode;
        logic [2:0] gain_code;
        logic unipolar;
        logic buffer_en;
        logic filter_sync;
        logic filter_rate_select_hi;
        logic filter_rate_select_lo;
        logic master_clock_halve;
        logic mclk_fast;
        logic clock_disable;
    } asr_cfg_t;

    // axi4-lite slave state
    typedef struct packed {
        logic aw_got;
        logic w_got;
        logic [7:0] awaddr;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } asr_axi_t;

    // whole module state
    typedef struct packed {
        logic sclk_m;
        logic sclk_s;
        logic sclk_d;
        logic din_m;
        logic din_s;
        asr_phase_t phase;
        logic [4:0] cnt;
        logic [4:0] ones;
        logic [23:0] sh;
        logic [6:0] comm;
        logic [7:0] setup;
        logic [7:0] clkr;
        logic [7:0] test;
        logic [15:0] data;
        logic [2:0][23:0] offs;
        logic [2:0][23:0] gain;
        logic ready;
        logic [3:0] status;
        logic [3:0] mask;
        asr_axi_t axi;
    } asr_state_t;

endpackage : asr_pkg

// ==== core/asr_serial_regs.sv ====
// serial register-access front end with axi4-lite status side
//
// Operation
// - eight internal registers, reached only through the serial port; AXI4-Lite here also writes data and reads data, command, setup and clock
// - after reset the interface expects a command register write
// - command value picks next transfer direction and target register
// - register write: command first, then new contents shifted in
// - register read, command and data included, set up by a command
// - command register also holds standby and input channel selection
// - reading the command register returns the conversion-ready status
// - setup register holds calibration mode, gain, coding, buffer enable
// - clock register holds filter rate field and master clock bits
// - conversion results are read from a dedicated data register
// - offset and gain registers keep per-channel calibration coefficients
// - two-bit filter field selects one of four rates per master clock
// - 32 serial clocks with data high reset the interface
// - three-bit target code fixes each register and its width
// - direction bit 0 writes, 1 reads the addressed register
// - leading command bit must be 0; ones there are skipped
//
// Implementation choices: the register offsets and the AXI4-Lite slave port.
`include "asr_consts.svh"
`timescale 1ns/1ns
`default_nettype none

module asr_serial_regs (
    // clock and reset
    input wire logic clk,
    input wire logic srst,
    // serial pins
    input wire logic sclk_pin,
    input wire logic din_pin,
    output logic dout_pin,
    output logic conversion_ready_n,
    // converter side
    output asr_pkg::asr_cfg_t cfg,
    output logic [15:0] update_rate_hz,
    output logic [23:0] active_offset,
    output logic [23:0] active_gain,
    // axi4-lite write
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // interrupt
    output logic irq
);

    ////////////////////////////////////////////////////////////////////////////
    // decode helpers

    function automatic logic [4:0] reg_width(input logic [2:0] sel);
        case (sel)
            `ASR_SEL_DATA: reg_width = `ASR_W16;
            `ASR_SEL_OFFS, `ASR_SEL_GAIN: reg_width = `ASR_W24;
            default: reg_width = `ASR_W8;
        endcase
    endfunction : reg_width

    // target field of a command word
    function automatic logic [2:0] target_of(input logic [6:0] c);
        target_of = c[`ASR_CMD_SEL_HI:`ASR_CMD_SEL_LO];
    endfunction : target_of

    // no-op and command writes need no register transfer
    function automatic logic cmd_only(input logic [6:0] c);
        cmd_only = target_of(c) == `ASR_SEL_NOP ||
                   (target_of(c) == `ASR_SEL_COMM && !c[`ASR_CMD_RD]);
    endfunction : cmd_only

    // channel codes 00 and 10 share a coefficient pair
    function automatic logic [1:0] cal_pair(input logic [1:0] ch);
        case (ch)
            2'h1: cal_pair = 2'h1;
            2'h3: cal_pair = 2'h2;
            default: cal_pair = 2'h0;
        endcase
    endfunction : cal_pair

    function automatic logic [15:0] rate_of(input logic fast, input logic [1:0] fs);
        case ({fast, fs})
            3'h4: rate_of = `ASR_RATE_FAST_0;
            3'h5: rate_of = `ASR_RATE_FAST_1;
            3'h6: rate_of = `ASR_RATE_FAST_2;
            3'h7: rate_of = `ASR_RATE_FAST_3;
            3'h0: rate_of = `ASR_RATE_SLOW_0;
            3'h1: rate_of = `ASR_RATE_SLOW_1;
            3'h2: rate_of = `ASR_RATE_SLOW_2;
            default: rate_of = `ASR_RATE_SLOW_3;
        endcase
    endfunction : rate_of

    ////////////////////////////////////////////////////////////////////////////
    // state

    asr_pkg::asr_state_t r;
    asr_pkg::asr_state_t n;
    logic rise;
    logic fall;
    logic bit_in;
    logic [2:0] sel;
    logic [6:0] cmdv;
    logic [23:0] wv;
    logic [3:0] ev;
    logic [3:0] clr;
    logic [1:0] pair;

    assign rise = r.sclk_s & ~r.sclk_d;
    assign fall = ~r.sclk_s & r.sclk_d;
    assign bit_in = r.din_s;
    assign sel = target_of(r.comm);
    assign pair = cal_pair(r.comm[`ASR_CMD_CH_HI:`ASR_CMD_CH_LO]);

    always_comb begin
        n = r;
        ev = 4'h0;
        clr = 4'h0;
        cmdv = {r.sh[5:0], bit_in};
        wv = {r.sh[22:0], bit_in};
        // pins pass two flip-flops; edge detect compares the second with a third, delayed copy
        n.sclk_m = sclk_pin;
        n.sclk_s = r.sclk_m;
        n.sclk_d = r.sclk_s;
        n.din_m = din_pin;
        n.din_s = r.din_m;

        if (rise) begin
            n.ones = bit_in ? r.ones + 5'h01 : 5'h00;
            case (r.phase)
                asr_pkg::ASR_PH_CMD: begin
                    // a 1 in the leading slot is not clocked in
                    if (r.cnt != 5'h00 || !bit_in) begin
                        n.sh = {r.sh[22:0], bit_in};
                        n.cnt = r.cnt + 5'h01;
                        if (r.cnt == `ASR_CMD_BITS) begin
                            n.comm = cmdv;
                            n.cnt = 5'h00;
                            ev[`ASR_EV_CMD] = 1'b1;
                            if (cmd_only(cmdv)) begin
                                n.phase = asr_pkg::ASR_PH_CMD;
                            end else if (cmdv[`ASR_CMD_RD]) begin
                                n.phase = asr_pkg::ASR_PH_RD;
                                // load left aligned so the msb leaves first
                                case (target_of(cmdv))
                                    `ASR_SEL_COMM: n.sh = {~r.ready, cmdv, 16'h0000};
                                    `ASR_SEL_SETUP: n.sh = {r.setup, 16'h0000};
                                    `ASR_SEL_CLOCK: n.sh = {r.clkr, 16'h0000};
                                    `ASR_SEL_DATA: n.sh = {r.data, 8'h00};
                                    `ASR_SEL_TEST: n.sh = {r.test, 16'h0000};
                                    `ASR_SEL_OFFS: n.sh = r.offs[cal_pair(cmdv[1:0])];
                                    default: n.sh = r.gain[cal_pair(cmdv[1:0])];
                                endcase
                            end else begin
                                n.phase = asr_pkg::ASR_PH_WR;
                            end
                        end
                    end
                end
                asr_pkg::ASR_PH_WR: begin
                    n.sh = wv;
                    n.cnt = r.cnt + 5'h01;
                    if (r.cnt == reg_width(sel) - 5'h01) begin
                        case (sel)
                            `ASR_SEL_SETUP: n.setup = wv[7:0];
                            `ASR_SEL_CLOCK: n.clkr = wv[7:0];
                            `ASR_SEL_DATA: n.data = wv[15:0];
                            `ASR_SEL_TEST: n.test = wv[7:0];
                            `ASR_SEL_OFFS: n.offs[pair] = wv;
                            `ASR_SEL_GAIN: n.gain[pair] = wv;
                            default: n.test = r.test;
                        endcase
                        n.cnt = 5'h00;
                        n.phase = asr_pkg::ASR_PH_CMD;
                        ev[`ASR_EV_WR] = 1'b1;
                    end
                end
                asr_pkg::ASR_PH_RD: begin
                    n.cnt = r.cnt + 5'h01;
                    if (r.cnt == reg_width(sel) - 5'h01) begin
                        n.cnt = 5'h00;
                        n.phase = asr_pkg::ASR_PH_CMD;
                        ev[`ASR_EV_RD] = 1'b1;
                        if (sel == `ASR_SEL_DATA) begin
                            n.ready = 1'b0;
                        end
                    end
                end
                default: begin
                    n.phase = asr_pkg::ASR_PH_CMD;
                    n.cnt = 5'h00;
                end
            endcase
            // lost framing: a run of ones puts the interface back to reset
            if (bit_in && r.ones == `ASR_RESYNC_ONES) begin
                // data and coefficients are kept; only control words return
                n.phase = asr_pkg::ASR_PH_CMD;
                n.cnt = 5'h00;
                n.ones = 5'h00;
                n.comm = `ASR_RST_COMM;
                n.setup = `ASR_RST_SETUP;
                n.clkr = `ASR_RST_CLOCK;
                n.test = `ASR_RST_TEST;
                ev = 4'h0;
                ev[`ASR_EV_SYNC] = 1'b1;
            end
        end
        // data changes on the falling edge, first bit already on the pin
        if (fall && r.phase == asr_pkg::ASR_PH_RD && r.cnt != 5'h00) begin
            n.sh = {r.sh[22:0], 1'b0};
        end

        // axi write channels, taken in either order
        if (s_axi_awvalid && s_axi_awready) begin
            n.axi.aw_got = 1'b1;
            n.axi.awaddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            n.axi.w_got = 1'b1;
            n.axi.wdata = s_axi_wdata;
            n.axi.wstrb = s_axi_wstrb;
        end
        if (r.axi.aw_got && r.axi.w_got) begin
            n.axi.aw_got = 1'b0;
            n.axi.w_got = 1'b0;
            n.axi.bvalid = 1'b1;
            n.axi.bresp = `ASR_RESP_OKAY;
            case (r.axi.awaddr)
                `ASR_A_STATUS: n.axi.bresp = `ASR_RESP_OKAY;
                `ASR_A_MASK: begin
                    if (r.axi.wstrb[0]) begin
                        n.mask = r.axi.wdata[3:0];
                    end
                end
                `ASR_A_RESULT: begin
                    // new result wins over a data read ending this cycle
                    if (&r.axi.wstrb[1:0]) begin
                        n.data = r.axi.wdata[15:0];
                        n.ready = 1'b1;
                    end
                end
                default: n.axi.bresp = `ASR_RESP_SLVERR;
            endcase
        end
        if (r.axi.bvalid && s_axi_bready) begin
            n.axi.bvalid = 1'b0;
        end

        // axi read
        if (s_axi_arvalid && s_axi_arready) begin
            n.axi.rvalid = 1'b1;
            n.axi.rresp = `ASR_RESP_OKAY;
            n.axi.rdata = 32'h00000000;
            case (s_axi_araddr)
                `ASR_A_STATUS: begin
                    n.axi.rdata = {28'h0000000, r.status};
                    clr = r.status;
                end
                `ASR_A_MASK: n.axi.rdata = {28'h0000000, r.mask};
                `ASR_A_RESULT: n.axi.rdata = {16'h0000, r.data};
                `ASR_A_SERIAL: n.axi.rdata = {5'h00, r.ready, 2'(r.phase), 1'b0, r.comm,
                                              r.setup, r.clkr};
                default: n.axi.rresp = `ASR_RESP_SLVERR;
            endcase
        end else if (r.axi.rvalid && s_axi_rready) begin
            n.axi.rvalid = 1'b0;
        end

        // sticky events; a new event beats the read that clears
        n.status = (r.status & ~clr) | ev;
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            r <= '0;
            // link clock idles high: a low reset value would fake a rising edge
            r.sclk_m <= 1'b1;
            r.sclk_s <= 1'b1;
            r.sclk_d <= 1'b1;
            r.phase <= asr_pkg::ASR_PH_CMD;
            r.comm <= `ASR_RST_COMM;
            r.setup <= `ASR_RST_SETUP;
            r.clkr <= `ASR_RST_CLOCK;
            r.test <= `ASR_RST_TEST;
            r.data <= `ASR_RST_DATA;
            r.offs <= {3{`ASR_RST_OFFS}};
            r.gain <= {3{`ASR_RST_GAIN}};
        end else begin
            r <= n;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs

    assign dout_pin = r.sh[23];
    assign conversion_ready_n = ~r.ready;
    assign cfg.low_power_hold = r.comm[`ASR_CMD_HOLD];
    assign cfg.input_channel_select = r.comm[`ASR_CMD_CH_HI:`ASR_CMD_CH_LO];
    assign cfg.cal_mode = r.setup[`ASR_SU_MODE_HI:`ASR_SU_MODE_LO];
    assign cfg.gain_code = r.setup[`ASR_SU_GAIN_HI:`ASR_SU_GAIN_LO];
    assign cfg.unipolar = r.setup[`ASR_SU_UNI];
    assign cfg.buffer_en = r.setup[`ASR_SU_BUF];
    assign cfg.filter_sync = r.setup[`ASR_SU_SYNC];
    assign cfg.filter_rate_select_hi = r.clkr[`ASR_CK_FS_HI];
    assign cfg.filter_rate_select_lo = r.clkr[`ASR_CK_FS_LO];
    assign cfg.master_clock_halve = r.clkr[`ASR_CK_HALVE];
    assign cfg.mclk_fast = r.clkr[`ASR_CK_MSEL];
    assign cfg.clock_disable = r.clkr[`ASR_CK_DIS];
    // rate assumes halving off; with it on the master clock pin is doubled
    assign update_rate_hz = rate_of(r.clkr[`ASR_CK_MSEL],
                                    r.clkr[`ASR_CK_FS_HI:`ASR_CK_FS_LO]);
    assign active_offset = r.offs[cal_pair(r.comm[1:0])];
    assign active_gain = r.gain[cal_pair(r.comm[1:0])];

    assign s_axi_awready = ~r.axi.aw_got & ~r.axi.bvalid;
    assign s_axi_wready = ~r.axi.w_got & ~r.axi.bvalid;
    assign s_axi_bvalid = r.axi.bvalid;
    assign s_axi_bresp = r.axi.bresp;
    assign s_axi_arready = ~r.axi.rvalid;
    assign s_axi_rvalid = r.axi.rvalid;
    assign s_axi_rdata = r.axi.rdata;
    assign s_axi_rresp = r.axi.rresp;
    assign irq = |(r.status & r.mask);

endmodule : asr_serial_regs

`default_nettype wire

// ==== tb/asr_chk_sva.sv ====
// port assertions of the serial register front end
`timescale 1ns/1ns
`default_nettype none

module asr_chk (
    // clock and reset
    input wire logic clk,
    input wire logic srst,
    // axi4-lite
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    // converter side
    input wire asr_pkg::asr_cfg_t cfg,
    input wire logic [15:0] update_rate_hz,
    input wire logic irq,
    input wire logic conversion_ready_n,
    input wire logic dout_pin
);
    // slow master clock rates first, then fast
    localparam logic [15:0] RT [0:7] = '{16'h0014, 16'h0019, 16'h0064, 16'h00C8,
        16'h0032, 16'h003C, 16'h00FA, 16'h01F4};
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);
    sequence wr_take;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence rd_take;
        s_axi_arvalid && s_axi_arready;
    endsequence
    ////////////////////////////////////////////////////////////////
    chk_reset_quiet: assert property ($fell(srst) |-> !s_axi_bvalid && !s_axi_rvalid
        && !irq && conversion_ready_n && cfg == '0 && !dout_pin)
        else $error("outputs not quiet after reset");
    chk_rate_table: assert property (update_rate_hz == RT[{cfg.mclk_fast,
        cfg.filter_rate_select_hi, cfg.filter_rate_select_lo}])
        else $error("update rate does not match rate field");
    chk_write_answer: assert property (wr_take |=> !s_axi_awready ##1 s_axi_bvalid)
        else $error("write response late");
    chk_b_release: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("write response not released");
    chk_read_answer: assert property (rd_take |=> s_axi_rvalid && !s_axi_arready)
        else $error("read response late");
    chk_r_release: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
        else $error("read response not released");
    chk_unmapped_read: assert property (rd_take
        and !(s_axi_araddr inside {8'h00, 8'h04, 8'h08, 8'h0C})
        |=> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0)
        else $error("unmapped read not refused");
    chk_ready_cause: assert property ($fell(conversion_ready_n)
        |-> $past(s_axi_wvalid && s_axi_wready) || $past(s_axi_wvalid && s_axi_wready, 2))
        else $error("ready flag set without result write");
endmodule : asr_chk

bind asr_serial_regs asr_chk u_chk (.clk, .srst, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
    .s_axi_arready, .s_axi_araddr, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata,
    .s_axi_rresp, .cfg, .update_rate_hz, .irq, .conversion_ready_n, .dout_pin);
`default_nettype wire

// ==== tb/asr_host.sv ====
// host serial port master model
`timescale 1ns/1ns
`default_nettype none

module asr_host (
    // clock
    input wire logic clk,
    // serial pins
    output logic sclk_pin,
    output logic din_pin,
    input wire logic dout_pin
);
    // sclk idles high and stands still between frames
    initial begin
        sclk_pin = 1'b1;
        din_pin = 1'b0;
    end
    // low 5 clk, high 3 clk: dout has settled well before the sampling rise
    task automatic xfer(input logic [23:0] tx, input int n, output logic [23:0] rx);
        rx = '0;
        for (int i = n - 1; i >= 0; i--) begin
            @(posedge clk);
            sclk_pin <= 1'b0;
            din_pin <= tx[i];
            repeat (5) @(posedge clk);
            rx[i] = dout_pin;
            sclk_pin <= 1'b1;
            repeat (2) @(posedge clk);
        end
        @(posedge clk);
        din_pin <= ~tx[0];
    endtask : xfer
endmodule : asr_host
`default_nettype wire

// ==== tb/tb.sv ====
// self-checking bench of the serial register front end
`timescale 1ns/1ns
`default_nettype none

module tb;
    logic clk, srst, sclk_pin, din_pin, dout_pin, conversion_ready_n, irq;
    asr_pkg::asr_cfg_t cfg;
    logic [15:0] update_rate_hz;
    logic [23:0] active_offset, active_gain, rx;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, rd;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp, rs;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    int failures, comparisons;
    logic [15:0] rt [0:7] = '{16'h0014, 16'h0019, 16'h0064, 16'h00C8,
        16'h0032, 16'h003C, 16'h00FA, 16'h01F4};

    asr_serial_regs DUT (.clk, .srst, .sclk_pin, .din_pin, .dout_pin, .conversion_ready_n,
        .cfg, .update_rate_hz, .active_offset, .active_gain, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .irq);
    asr_host host (.clk, .sclk_pin, .din_pin, .dout_pin);

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    ////////////////////////////////////////////////////////////////
    task automatic tally_and_finish;
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : tally_and_finish
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            failures++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        @(posedge clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge clk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask : axw
    task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge clk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask : axr
    // command byte, then a register transfer of n bits, then let the edge detector settle
    task automatic ser(input logic [7:0] c, input logic [23:0] v, input int n);
        host.xfer({16'h0, c}, 8, rx);
        if (n > 0) host.xfer(v, n, rx);
        repeat (4) @(posedge clk);
    endtask : ser
    ////////////////////////////////////////////////////////////////
    initial begin
        srst = 1'b1;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        s_axi_wstrb = 4'hF;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        {failures, comparisons} = '0;
        repeat (3) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        chk("cfg", 32'h0, cfg);
        chk("ready_n", 32'h1, conversion_ready_n);
        axr(8'h0C, rd, rs);
        chk("serial_view", 32'h0, rd);
        ser(8'h08, 24'h0, 8);
        chk("comm_read", 32'h88, rx[7:0]);
        $display("reset test done");
        for (int i = 0; i < 8; i++) begin
            ser(8'h20, {21'h0, i[2:0]}, 8);
            chk("rate", rt[i], update_rate_hz);
        end
        ser(8'h10, 24'hA5, 8);
        chk("setup", 32'hA5, {cfg.cal_mode, cfg.gain_code, cfg.unipolar, cfg.buffer_en, cfg.filter_sync});
        ser(8'h18, 24'h0, 8);
        chk("setup_read", 32'hA5, rx[7:0]);
        $display("setup and clock test done");
        host.xfer({13'h0, 3'b111, 8'h27}, 11, rx);
        host.xfer(24'h07, 8, rx);
        repeat (4) @(posedge clk);
        chk("rate_after_ones", 32'h01F4, update_rate_hz);
        chk("hold_channel", 32'h7, {cfg.low_power_hold, cfg.input_channel_select});
        $display("leading ones test done");
        axr(8'h00, rd, rs);
        axw(8'h04, 32'h4, rs);
        axw(8'h08, 32'hBEEF, rs);
        chk("ready_set", 32'h0, conversion_ready_n);
        ser(8'h10, 24'h0, 8);
        chk("irq_masked", 32'h0, irq);
        ser(8'h08, 24'h0, 8);
        chk("comm_ready", 32'h0, rx[7]);
        chk("irq_raised", 32'h1, irq);
        ser(8'h38, 24'h0, 16);
        chk("data_read", 32'hBEEF, rx[15:0]);
        chk("ready_clear", 32'h1, conversion_ready_n);
        axr(8'h00, rd, rs);
        chk("status", 32'h7, rd[3:0]);
        chk("irq_cleared", 32'h0, irq);
        $display("data and interrupt test done");
        ser(8'h61, 24'h123456, 24);
        ser(8'h71, 24'hABCDEF, 24);
        chk("offset", 32'h123456, active_offset);
        chk("gain", 32'hABCDEF, active_gain);
        ser(8'h69, 24'h0, 24);
        chk("offset_read", 32'h123456, rx);
        ser(8'h40, 24'h5A, 8);
        ser(8'h48, 24'h0, 8);
        chk("test_read", 32'h5A, rx[7:0]);
        ser(8'h51, 24'h0, 0);
        chk("nop_channel", 32'h123456, active_offset);
        ser(8'h79, 24'h0, 24);
        chk("gain_read", 32'hABCDEF, rx);
        ser(8'h04, 24'h0, 0);
        chk("comm_write", 32'h4, {cfg.low_power_hold, cfg.input_channel_select});
        $display("coefficient test done");
        ser(8'h10, 24'h0, 0);
        host.xfer(24'hFFFFFF, 24, rx);
        host.xfer(24'hFF, 8, rx);
        repeat (4) @(posedge clk);
        chk("resync_cfg", 32'h0, cfg);
        axr(8'h00, rd, rs);
        chk("resync_status", 32'h1, rd[3]);
        ser(8'h10, 24'h01, 8);
        chk("after_resync", 32'h1, cfg.filter_sync);
        axw(8'h10, 32'h1, rs);
        chk("bad_write", 32'h2, rs);
        axr(8'h14, rd, rs);
        chk("bad_read", 32'h2, rs);
        chk("bad_data", 32'h0, rd);
        $display("resync and refusal test done");
        tally_and_finish();
    end
    initial begin
        #1000000;
        failures++;
        $display("ERROR watchdog expected finish seen timeout");
        tally_and_finish();
    end
endmodule : tb
`default_nettype wire
